// >>> srcf_pkg.sv
// constants shared by the secure remote command frame checker
// assumes one clock and apb access to the register file
package srcf_pkg;
   // ==========================================================
   // frame bytes and codes
   localparam logic [7:0] SRCF_DELIM = 8'h7e;
   localparam logic [7:0] SRCF_TYPE_PLAIN = 8'h17;
   localparam logic [7:0] SRCF_TYPE_SECURE = 8'h18;
   localparam logic [7:0] SRCF_TYPE_RESPONSE = 8'h97;
   localparam logic [7:0] SRCF_CSUM_GOOD = 8'hff;
   localparam logic [7:0] SRCF_TAG_SILENT = 8'h00;
   localparam int SRCF_APPLY_BIT = 1;
   // ==========================================================
   // body byte index, counted from the frame type byte (offset 3)
   localparam logic [15:0] SRCF_IDX_TAG = 16'h0001;
   localparam logic [15:0] SRCF_IDX_PWLEN = 16'h0002;
   localparam logic [15:0] SRCF_IDX_PW = 16'h0003;
   localparam logic [15:0] SRCF_BASE_PLAIN = 16'h0002;
   // positions relative to the first destination byte
   localparam logic [15:0] SRCF_REL_DEST_LAST = 16'h0007;
   localparam logic [15:0] SRCF_REL_OPT = 16'h000a;
   localparam logic [15:0] SRCF_REL_CMD_HI = 16'h000b;
   localparam logic [15:0] SRCF_REL_CMD_LO = 16'h000c;
   localparam logic [15:0] SRCF_REL_PARAM = 16'h000d;
   // ==========================================================
   // apb register map (byte addresses)
   localparam logic [7:0] SRCF_REG_CTRL = 8'h00;
   localparam logic [7:0] SRCF_REG_PWLEN = 8'h04;
   localparam logic [7:0] SRCF_REG_PW0 = 8'h08;
   localparam logic [7:0] SRCF_REG_STAT = 8'h10;
   localparam logic [7:0] SRCF_REG_LAST = 8'h14;
   localparam int SRCF_CTRL_EE_BIT = 0;
   localparam logic [31:0] SRCF_CTRL_RESET = 32'h0000_0000;
   localparam logic [7:0] SRCF_PWLEN_RESET = 8'h00;
   // ==========================================================
   // parser states and verdict codes
   typedef enum logic [2:0] {
      SRCF_ST_SYNC, SRCF_ST_LEN_HI, SRCF_ST_LEN_LO, SRCF_ST_BODY, SRCF_ST_CSUM
   } srcf_state_t;
   typedef enum logic [2:0] {
      SRCF_WHY_NONE, SRCF_WHY_CSUM, SRCF_WHY_LOCKED, SRCF_WHY_AUTH, SRCF_WHY_FORMAT
   } srcf_why_t;
endpackage

// >>> srcf_csum.sv
// running 8-bit checksum over the frame body
// assumes the parser pulses clear on the start delimiter
module srcf_csum
   import srcf_pkg::*;
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // byte feed
   input wire logic clear,
   input wire logic add,
   input wire logic [7:0] in_byte,
   // verdict on the byte now presented as the checksum
   output logic good
);
   logic [7:0] sum;
   logic [7:0] next_sum;

   // ==========================================================
   // accumulate
   // sum wraps on purpose: only the low eight bits count
   assign next_sum = clear ? 8'h00 : (add ? 8'(sum + in_byte) : sum);
   assign good = (8'(sum + in_byte) == SRCF_CSUM_GOOD); // R15

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sum <= 8'h00;
      end else begin
         sum <= next_sum;
      end
   end
endmodule

// >>> srcf_frame.sv
// secure remote command frame checker: parses request frames from the
// host byte stream and decides whether a command may be executed
// assumes bytes arrive unescaped, one per rx_valid cycle, synchronous to pclk

// How it works
// [R1] secure request frames carry type 0x18 plus a password
// [R2] byte at offset 4 is the tag echoed in the 0x97 response
// [R3] offset 5 holds password length, password bytes follow from offset 6
// [R4] 64-bit destination follows the password, most significant byte first
// [R5] two reserved bytes after the destination are ignored
// [R6] options bit 1 requests immediate apply, else changes wait
// [R7] two ascii command bytes follow the options byte
// [R8] optional parameter follows the command; absent means a query
// [R9] with a password set, plain 0x17 requests are refused
// [R10] with a password set, secure ones need correct password and encryption
// [R11] with a password set, network commands need a protected sender
// [R12] with no password set, plain 0x17 requests are accepted
// [R13] host may send secure requests with password ascii zero when unset
// [R14] 16-bit length counts bytes between length field and checksum
// [R15] checksum is 0xff minus the 8-bit sum from offset 3 on
// [R16] tag zero suppresses the response frame
// [R17] frames open with 0x7e then the length; receiver hunts for it
// [R18] frames with a bad checksum are dropped without action
module srcf_frame
   import srcf_pkg::*;
#(
   parameter int PW_MAX = 8,
   parameter int PARAM_MAX = 8
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // host byte stream
   input wire logic rx_valid,
   input wire logic [7:0] rx_byte,
   // accepted command
   output logic cmd_valid,
   output logic cmd_secure,
   output logic [7:0] cmd_tag,
   output logic cmd_respond,
   output logic [63:0] cmd_dest,
   output logic cmd_apply,
   output logic [15:0] cmd_name,
   output logic [PARAM_MAX*8-1:0] cmd_param,
   output logic [15:0] cmd_param_len,
   // refused frame
   output logic frame_reject,
   output logic [2:0] reject_why,
   // commands arriving from other nodes
   input wire logic net_cmd_valid,
   input wire logic net_src_protected,
   output logic net_cmd_accept
);
   localparam int PW_WORDS = (PW_MAX + 3) / 4;

   srcf_state_t st;
   srcf_state_t next_st;
   logic [31:0] ctrl;
   logic [7:0] remote_cmd_password_len;
   logic [31:0] pw_word [PW_WORDS];
   logic [PW_WORDS*32-1:0] pw_flat;
   logic [15:0] len;
   logic [15:0] idx;
   logic [7:0] ftype;
   logic [7:0] pl;
   logic pw_ok;
   logic [7:0] param_mem [PARAM_MAX];
   logic [7:0] acc_cnt;
   logic [7:0] rej_cnt;
   logic [2:0] last_why;

   // ==========================================================
   // apb decode; zero wait states, read data captured in setup
   logic wr_en;
   logic rd_setup;
   logic hit;
   logic [31:0] rd_mux;
   logic encryption_enable;
   logic locked;
   assign pready = 1'b1;
   assign wr_en = psel & penable & pwrite;
   assign rd_setup = psel & ~penable & ~pwrite;
   assign hit = (paddr == SRCF_REG_CTRL) | (paddr == SRCF_REG_PWLEN)
      | (paddr == SRCF_REG_STAT) | (paddr == SRCF_REG_LAST)
      | ((paddr >= SRCF_REG_PW0) && (paddr < 8'(SRCF_REG_PW0 + 4 * PW_WORDS))
         && (paddr[1:0] == 2'b00));
   assign pslverr = psel & penable & ~hit;
   assign encryption_enable = ctrl[SRCF_CTRL_EE_BIT];
   assign locked = (remote_cmd_password_len != 8'h00);

   always_comb begin
      rd_mux = 32'h0000_0000;
      if (paddr == SRCF_REG_CTRL) rd_mux = ctrl;
      if (paddr == SRCF_REG_PWLEN) rd_mux = {24'h000000, remote_cmd_password_len};
      if (paddr == SRCF_REG_STAT) rd_mux = {16'h0000, rej_cnt, acc_cnt};
      if (paddr == SRCF_REG_LAST) rd_mux = {13'h0, last_why, 8'h00, cmd_tag};
      for (int w = 0; w < PW_WORDS; w++) begin
         if (paddr == 8'(SRCF_REG_PW0 + 4 * w)) rd_mux = pw_word[w];
      end
   end

   // control registers; reserved ctrl bits read back as zero
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl <= SRCF_CTRL_RESET;
         remote_cmd_password_len <= SRCF_PWLEN_RESET;
         prdata <= 32'h0000_0000;
      end else begin
         if (wr_en && paddr == SRCF_REG_CTRL) ctrl <= pwdata & 32'h0000_0001;
         if (wr_en && paddr == SRCF_REG_PWLEN) remote_cmd_password_len <= pwdata[7:0];
         if (rd_setup) prdata <= hit ? rd_mux : 32'h0000_0000;
      end
   end

   // password store, four bytes a word, byte k at word k/4 lane k%4
   for (genvar w = 0; w < PW_WORDS; w++) begin : g_pw
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            pw_word[w] <= 32'h0000_0000;
         end else if (wr_en && paddr == 8'(SRCF_REG_PW0 + 4 * w)) begin
            pw_word[w] <= pwdata;
         end
      end
      assign pw_flat[w*32 +: 32] = pw_word[w];
   end

   // ==========================================================
   // field positions for the frame in progress
   logic secure;
   logic plain;
   logic [15:0] base;
   logic [15:0] rel;
   logic [15:0] min_len;
   logic in_fields;
   logic in_pw;
   logic [15:0] pw_k;
   logic [15:0] par_k;
   logic last_body;
   logic csum_good;
   logic pw_match;
   logic bad_len;
   logic body_byte;
   logic end_byte;
   assign secure = (ftype == SRCF_TYPE_SECURE); // R1
   assign plain = (ftype == SRCF_TYPE_PLAIN);
   // destination starts right after the password bytes
   assign base = secure ? 16'(SRCF_IDX_PW + {8'h00, pl}) : SRCF_BASE_PLAIN; // R4
   assign rel = 16'(idx - base);
   assign in_fields = (idx >= base) && (plain || idx > SRCF_IDX_PWLEN);
   assign in_pw = secure && idx >= SRCF_IDX_PW && idx < base; // R3
   assign pw_k = 16'(idx - SRCF_IDX_PW);
   assign par_k = 16'(rel - SRCF_REL_PARAM);
   assign min_len = 16'(base + SRCF_REL_PARAM);
   assign last_body = (idx == 16'(len - 16'h0001)); // R14
   assign body_byte = rx_valid && st == SRCF_ST_BODY;
   assign end_byte = rx_valid && st == SRCF_ST_CSUM;
   assign pw_match = pw_ok && (pl == remote_cmd_password_len);
   // parameters longer than the store are refused rather than cut
   assign bad_len = (len < min_len) || (16'(len - min_len) > 16'(PARAM_MAX));

   srcf_csum u_csum (
      .pclk(pclk),
      .presetn(presetn),
      .clear(rx_valid && st == SRCF_ST_SYNC),
      .add(body_byte),
      .in_byte(rx_byte),
      .good(csum_good)
   );

   // ==========================================================
   // verdict at the checksum byte
   logic known;
   logic accept;
   srcf_why_t why;
   assign known = (secure | plain) && len != 16'h0000;
   always_comb begin
      why = SRCF_WHY_NONE;
      if (!csum_good) why = SRCF_WHY_CSUM; // R18
      else if (bad_len) why = SRCF_WHY_FORMAT;
      else if (plain && locked) why = SRCF_WHY_LOCKED; // R9
      else if (secure && locked && !(pw_match && encryption_enable)) why = SRCF_WHY_AUTH; // R10
   end
   // unlocked: plain frames and secure ones with any password pass
   assign accept = end_byte && known && why == SRCF_WHY_NONE; // R12 R13

   // ==========================================================
   // parser state; only a delimiter leaves the hunt
   always_comb begin
      next_st = st;
      if (rx_valid) begin
         case (st)
            SRCF_ST_SYNC: if (rx_byte == SRCF_DELIM) next_st = SRCF_ST_LEN_HI; // R17
            SRCF_ST_LEN_HI: next_st = SRCF_ST_LEN_LO;
            SRCF_ST_LEN_LO: next_st = ({len[7:0], rx_byte} == 16'h0000) ? SRCF_ST_CSUM
               : SRCF_ST_BODY;
            SRCF_ST_BODY: if (last_body) next_st = SRCF_ST_CSUM; // R14
            SRCF_ST_CSUM: next_st = SRCF_ST_SYNC;
            default: next_st = SRCF_ST_SYNC;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) st <= SRCF_ST_SYNC;
      else st <= next_st;
   end

   // length, index and header bytes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         len <= 16'h0000;
         idx <= 16'h0000;
         ftype <= 8'h00;
         pl <= 8'h00;
      end else if (rx_valid) begin
         if (st == SRCF_ST_LEN_HI || st == SRCF_ST_LEN_LO) len <= {len[7:0], rx_byte};
         if (st == SRCF_ST_LEN_LO) idx <= 16'h0000;
         if (body_byte) idx <= 16'(idx + 16'h0001);
         if (body_byte && idx == 16'h0000) ftype <= rx_byte;
         if (body_byte && idx == SRCF_IDX_PWLEN) pl <= rx_byte; // R3
      end
   end

   // password compare, byte by byte as they pass
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pw_ok <= 1'b0;
      end else if (rx_valid && st == SRCF_ST_LEN_LO) begin
         pw_ok <= 1'b1;
      end else if (body_byte && in_pw) begin
         if (pw_k >= 16'(PW_MAX) || rx_byte != pw_flat[pw_k[7:0]*8 +: 8]) pw_ok <= 1'b0;
      end
   end

   // command fields; they hold from cmd_valid until the next frame overwrites
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cmd_tag <= 8'h00;
         cmd_dest <= 64'h0;
         cmd_apply <= 1'b0;
         cmd_name <= 16'h0000;
      end else if (body_byte) begin
         if (idx == SRCF_IDX_TAG) cmd_tag <= rx_byte; // R2
         if (in_fields && rel <= SRCF_REL_DEST_LAST) cmd_dest <= {cmd_dest[55:0], rx_byte}; // R4
         // the two reserved bytes fall between and are never stored
         if (in_fields && rel == SRCF_REL_OPT) cmd_apply <= rx_byte[SRCF_APPLY_BIT]; // R5 R6
         if (in_fields && rel == SRCF_REL_CMD_HI) cmd_name[15:8] <= rx_byte; // R7
         if (in_fields && rel == SRCF_REL_CMD_LO) cmd_name[7:0] <= rx_byte; // R7
      end
   end

   // parameter bytes, first byte in the lowest lane
   for (genvar p = 0; p < PARAM_MAX; p++) begin : g_par
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            param_mem[p] <= 8'h00;
         end else if (body_byte && in_fields && rel >= SRCF_REL_PARAM
               && par_k == 16'(p)) begin
            param_mem[p] <= rx_byte; // R8
         end
      end
      assign cmd_param[p*8 +: 8] = param_mem[p];
   end

   // ==========================================================
   // outcome strobes and counters
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cmd_valid <= 1'b0;
         cmd_secure <= 1'b0;
         cmd_param_len <= 16'h0000;
         frame_reject <= 1'b0;
         reject_why <= 3'h0;
         acc_cnt <= 8'h00;
         rej_cnt <= 8'h00;
         last_why <= 3'h0;
      end else begin
         cmd_valid <= accept;
         frame_reject <= end_byte && known && why != SRCF_WHY_NONE;
         if (accept) begin
            cmd_secure <= secure;
            cmd_param_len <= 16'(len - min_len); // R8
            acc_cnt <= 8'(acc_cnt + 8'h01);
         end
         if (end_byte && known && why != SRCF_WHY_NONE) begin
            reject_why <= why;
            last_why <= why;
            rej_cnt <= 8'(rej_cnt + 8'h01);
         end
      end
   end

   assign cmd_respond = cmd_valid && cmd_tag != SRCF_TAG_SILENT; // R16
   assign net_cmd_accept = net_cmd_valid && (!locked || net_src_protected); // R11

   // ==========================================================
   // checks
   sequence s_delim;
      st == SRCF_ST_SYNC && rx_valid && rx_byte == SRCF_DELIM;
   endsequence
   sequence s_len_in;
      rx_valid [*2];
   endsequence

   chk_delim_hunt: assert property (@(posedge pclk) disable iff (!presetn) // R17
      s_delim ##1 s_len_in |=> st != SRCF_ST_SYNC && st != SRCF_ST_LEN_HI)
      else $error("length bytes after delimiter not consumed");
   chk_body_end: assert property (@(posedge pclk) disable iff (!presetn) // R14
      body_byte && last_body |=> st == SRCF_ST_CSUM)
      else $error("body did not end at length");
   chk_bad_csum: assert property (@(posedge pclk) disable iff (!presetn) // R18
      end_byte && known && !csum_good |=> !cmd_valid && frame_reject)
      else $error("bad checksum not refused");
   chk_plain_locked: assert property (@(posedge pclk) disable iff (!presetn) // R9
      cmd_valid && !cmd_secure |-> $past(!locked))
      else $error("plain request passed while locked");
   chk_secure_auth: assert property (@(posedge pclk) disable iff (!presetn) // R10
      cmd_valid && cmd_secure && $past(locked) |-> $past(pw_match && encryption_enable))
      else $error("secure request passed without password and encryption");
   chk_plain_open: assert property (@(posedge pclk) disable iff (!presetn) // R12
      end_byte && plain && !locked && csum_good && !bad_len |=> cmd_valid)
      else $error("plain request refused while unlocked");
   chk_silent_tag: assert property (@(posedge pclk) disable iff (!presetn) // R16
      cmd_valid && $past(cmd_tag == SRCF_TAG_SILENT, 2) && $stable(cmd_tag) |-> !cmd_respond)
      else $error("response raised for tag zero");
   chk_net_gate: assert property (@(posedge pclk) disable iff (!presetn) // R11
      net_cmd_valid && locked && !net_src_protected |-> !net_cmd_accept)
      else $error("network command from unprotected sender accepted");
   chk_type_code: assert property (@(posedge pclk) disable iff (!presetn) // R1
      cmd_valid |-> $past(ftype) == (cmd_secure ? SRCF_TYPE_SECURE : SRCF_TYPE_PLAIN))
      else $error("accepted frame type wrong");
endmodule

// >>> srcf_host_model.sv
// host side model: frames request bodies onto the device's byte stream
// assumes the device clock and reset; the device never stalls the host
module srcf_host_model
   import srcf_pkg::*;
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // pacing: high leaves an idle cycle after every byte
   input wire logic slow,
   // byte stream to the device
   output logic rx_valid,
   output logic [7:0] rx_byte
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] q[$];
   logic gap = 1'b0;
   initial rx_valid = 1'b0;
   initial rx_byte = 8'h00;
   // wraps a body in delimiter, length and checksum; bad spoils the sum
   task automatic send(input logic [7:0] body[$], input logic bad);
      logic [7:0] sum;
      sum = 8'h00;
      q.push_back(SRCF_DELIM);
      q.push_back(8'(body.size() >> 8));
      q.push_back(8'(body.size()));
      foreach (body[i]) begin
         q.push_back(body[i]);
         sum += body[i];
      end
      q.push_back((8'hff - sum) ^ {7'h00, bad});
   endtask
   // one byte per edge, or per other edge when slow; an idle line toggles so stale data never looks valid
   always @(posedge pclk) begin
      gap <= slow & ~gap;
      if (presetn && q.size() != 0 && !(slow && gap)) begin
         rx_valid <= 1'b1;
         rx_byte <= q.pop_front();
      end else begin
         rx_valid <= 1'b0;
         rx_byte <= ~rx_byte;
      end
   end
endmodule

// >>> secure_remote_cmd_frame_tb.sv
// self-checking bench for the secure remote command frame checker
// assumes srcf_pkg, srcf_frame and srcf_host_model compile before it
module secure_remote_cmd_frame_tb
   import srcf_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct {
      logic ok;
      logic [2:0] why;
      logic sec;
      logic [7:0] tag;
      logic [63:0] dest;
      logic apply;
      logic [15:0] name;
      logic [15:0] plen;
      logic [63:0] param;
   } srcf_exp_t;
   // ==========================================================
   // signals
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, slow = 1'b0, ee = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata;
   logic pready, pslverr, rx_valid, cmd_valid, cmd_secure, cmd_respond, cmd_apply;
   logic [7:0] rx_byte, cmd_tag;
   logic [63:0] cmd_dest, cmd_param;
   logic [63:0] xd = 64'h0013_a200_1234_5678;
   logic [15:0] cmd_name, cmd_param_len;
   logic frame_reject, net_cmd_accept;
   logic [2:0] reject_why;
   logic net_cmd_valid = 1'b0, net_src_protected = 1'b0;
   int bad_count = 0, n_checks = 0, cycles = 0, n_acc = 0, n_rej = 0;
   logic [31:0] seed = 32'h28;
   logic [7:0] cfg_pw[$], none[$], pw_ok[$] = '{8'h4e, 8'h75, 8'h67, 8'h67, 8'h65, 8'h74};
   srcf_exp_t exp_q[$], got;
   srcf_frame #(.PW_MAX(8), .PARAM_MAX(8)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .rx_valid(rx_valid), .rx_byte(rx_byte),
      .cmd_valid(cmd_valid), .cmd_secure(cmd_secure), .cmd_tag(cmd_tag),
      .cmd_respond(cmd_respond), .cmd_dest(cmd_dest), .cmd_apply(cmd_apply),
      .cmd_name(cmd_name), .cmd_param(cmd_param), .cmd_param_len(cmd_param_len),
      .frame_reject(frame_reject), .reject_why(reject_why), .net_cmd_valid(net_cmd_valid),
      .net_src_protected(net_src_protected), .net_cmd_accept(net_cmd_accept));
   srcf_host_model host (.pclk(pclk), .presetn(presetn), .slow(slow), .rx_valid(rx_valid),
      .rx_byte(rx_byte));
   initial begin
      forever #20 pclk = ~pclk;
   end
   // ==========================================================
   // helpers
   function automatic logic [7:0] xs8();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[7:0];
   endfunction
   task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
      n_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic final_report();
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // apb transfer; holds the request until pready is seen at an edge
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [31:0] xr, input logic xe);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      if (!w) check("prdata", 64'(prdata), 64'(xr));
      check("pslverr", 64'(pslverr), 64'(xe));
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   // builds one request, notes the verdict it must get, hands it to the host
   task automatic frame(input logic [7:0] typ, tag, input logic [7:0] pw[$],
                        input logic [63:0] dest, input logic [7:0] opt,
                        input logic [15:0] name, input logic [7:0] prm[$], input logic bad);
      logic [7:0] b[$];
      srcf_exp_t e;
      logic hit;
      b = {typ, tag};
      if (typ == SRCF_TYPE_SECURE) b = {b, 8'(pw.size()), pw};
      for (int i = 7; i >= 0; i--) b.push_back(dest[8*i +: 8]);
      b = {b, xs8(), xs8(), opt, name[15:8], name[7:0], prm};
      hit = ee && pw.size() == cfg_pw.size();
      foreach (pw[i]) if (i >= cfg_pw.size() || pw[i] !== cfg_pw[i]) hit = 1'b0;
      e.why = bad ? SRCF_WHY_CSUM : prm.size() > 8 ? SRCF_WHY_FORMAT :
              cfg_pw.size() == 0 ? SRCF_WHY_NONE : typ == SRCF_TYPE_PLAIN ? SRCF_WHY_LOCKED :
              hit ? SRCF_WHY_NONE : SRCF_WHY_AUTH;
      e.ok = e.why == SRCF_WHY_NONE;
      e.sec = typ == SRCF_TYPE_SECURE;
      e.tag = tag;
      e.dest = dest;
      e.apply = opt[SRCF_APPLY_BIT];
      e.name = name;
      e.plen = 16'(prm.size());
      e.param = 64'h0;
      foreach (prm[i]) e.param[8*i +: 8] = prm[i];
      if (typ == SRCF_TYPE_PLAIN || typ == SRCF_TYPE_SECURE) begin
         exp_q.push_back(e);
         if (e.ok) n_acc++;
         else n_rej++;
      end
      host.send(b, bad);
   endtask
   // random mix: password slips, short passwords, bad sums, 0..8 parameter bytes
   task automatic rand_frames(input int n, input logic pace);
      logic [7:0] pw[$], prm[$], r;
      slow <= pace;
      for (int k = 0; k < n; k++) begin
         pw = pw_ok;
         prm = {};
         r = xs8();
         if (r[2]) pw[r[7:5] % 6] ^= 8'h01;
         if (r[3]) void'(pw.pop_back());
         repeat (xs8() % 9) prm.push_back(xs8());
         frame(r[0] ? SRCF_TYPE_SECURE : SRCF_TYPE_PLAIN, xs8(), pw, {seed, xs8(), xs8(),
               xs8(), xs8()}, xs8(), {xs8(), xs8()}, prm, xs8() < 8'h20);
      end
   endtask
   task automatic wait_idle();
      while (host.q.size() != 0) @(posedge pclk);
      repeat (4) @(posedge pclk);
   endtask
   task automatic net_chk();
      for (int i = 0; i < 4; i++) begin
         net_cmd_valid <= i[0];
         net_src_protected <= i[1];
         @(posedge pclk);
         check("net_accept", 64'(net_cmd_accept), 64'(i[0] & (i[1] | cfg_pw.size() == 0)));
      end
   endtask
   // ==========================================================
   // result watcher: oldest note against each strobe
   always @(posedge pclk) begin
      if (cmd_valid === 1'b1 || frame_reject === 1'b1) begin
         got = exp_q.pop_front();
         check("accept", 64'(cmd_valid), 64'(got.ok));
         check("reject", 64'(frame_reject), 64'(!got.ok));
         if (got.ok) begin
            check("secure", 64'(cmd_secure), 64'(got.sec));
            check("tag", 64'(cmd_tag), 64'(got.tag));
            check("respond", 64'(cmd_respond), 64'(got.tag != 8'h00));
            check("dest", cmd_dest, got.dest);
            check("apply", 64'(cmd_apply), 64'(got.apply));
            check("name", 64'(cmd_name), 64'(got.name));
            check("plen", 64'(cmd_param_len), 64'(got.plen));
            check("param", cmd_param & ~({64{1'b1}} << 8 * got.plen), got.param);
         end else check("why", 64'(reject_why), 64'(got.why));
      end
   end
   // hang guard
   always @(posedge pclk) begin
      cycles++;
      if (cycles == 20000) begin
         bad_count++;
         final_report();
      end
   end
   // ==========================================================
   // main sequence
   initial begin
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      bus(0, SRCF_REG_CTRL, 32'h0, SRCF_CTRL_RESET, 0);
      bus(0, SRCF_REG_PWLEN, 32'h0, {24'h0, SRCF_PWLEN_RESET}, 0);
      bus(1, 8'h1c, 32'hffff_ffff, 32'h0, 1);
      bus(0, 8'h1c, 32'h0, 32'h0, 1);
      net_chk();
      host.q.push_back(8'h55);
      frame(SRCF_TYPE_PLAIN, 8'h00, none, xd, 8'h00, 16'h5450, none, 0);
      frame(SRCF_TYPE_SECURE, 8'h27, '{8'h30}, xd, 8'h02, 16'h4e49, pw_ok, 0);
      frame(SRCF_TYPE_PLAIN, 8'h68, none, xd, 8'h00, 16'h4944, pw_ok, 1);
      frame(8'h20, 8'h05, none, xd, 8'h00, 16'h4944, none, 0);
      frame(SRCF_TYPE_PLAIN, 8'h0a, none, xd, 8'h00, 16'h4944, {pw_ok, pw_ok}, 0);
      rand_frames(6, 1);
      wait_idle();
      // lock with a six byte password, encryption on
      bus(1, SRCF_REG_PW0, 32'h6767_754e, 32'h0, 0);
      bus(1, SRCF_REG_PW0 + 8'h04, 32'h0000_7465, 32'h0, 0);
      bus(1, SRCF_REG_PWLEN, 32'h6, 32'h0, 0);
      bus(1, SRCF_REG_CTRL, 32'h1, 32'h0, 0);
      bus(0, SRCF_REG_PWLEN, 32'h0, 32'h6, 0);
      cfg_pw = pw_ok;
      ee = 1'b1;
      net_chk();
      frame(SRCF_TYPE_SECURE, 8'h01, pw_ok, xd, 8'h02, 16'h4244, '{8'h07}, 0);
      frame(SRCF_TYPE_PLAIN, 8'h02, none, xd, 8'h02, 16'h4244, none, 0);
      rand_frames(12, 0);
      wait_idle();
      // encryption off: a correct password alone is not enough
      bus(1, SRCF_REG_CTRL, 32'h0, 32'h0, 0);
      ee = 1'b0;
      frame(SRCF_TYPE_SECURE, 8'h03, pw_ok, xd, 8'h00, 16'h4244, none, 0);
      wait_idle();
      bus(1, SRCF_REG_PWLEN, 32'h0, 32'h0, 0);
      cfg_pw = {};
      rand_frames(6, 0);
      wait_idle();
      // counters are read-only: the write must leave them alone
      bus(1, SRCF_REG_STAT, 32'hffff_ffff, 32'h0, 0);
      bus(0, SRCF_REG_STAT, 32'h0, {16'h0, n_rej[7:0], n_acc[7:0]}, 0);
      check("pending", 64'(exp_q.size()), 64'h0);
      final_report();
   end
endmodule
